// ---- logic/wmblm_pkg.sv ----
package wmblm_pkg;
    // Data-type sizes presented with each access
    typedef enum logic [1:0] {
        SIZE_8,
        SIZE_16,
        SIZE_32,
        SIZE_RSVD
    } wmblm_size_e;

    localparam int ADDR_W      = 24;
    localparam int DATA_W      = 32;
    localparam int LANES       = 4;
    localparam int LANE_W      = 8;
    localparam int ADDR_MSB    = 23;
    localparam int SHIFT_8     = 2;
    localparam int SHIFT_16    = 1;
    localparam int HALF_SEL    = 0;
    localparam logic [3:0] BE_IDLE_N  = 4'h f;
    localparam logic [3:0] BE_LOW_N   = 4'h c;
    localparam logic [3:0] BE_HIGH_N  = 4'h 3;
    localparam logic [3:0] BE_ALL_N   = 4'h 0;
    localparam logic [23:0] ADDR_RST  = 24'h00_0000;
    localparam logic [31:0] DATA_RST  = 32'h0000_0000;
endpackage : wmblm_pkg

// ---- logic/wmblm_lane_decode.sv ----
`timescale 1ns/1ps
module wmblm_lane_decode
(
    // Access description
    input  wire logic [23:0] i_addr,
    input  wire logic [1:0]  i_size,
    // Mapped result
    output logic      [23:0] o_ext_addr,
    output logic      [3:0]  o_be_n
);
    wire [1:0] lane_sel;
    wire [3:0] be8_n;
    wire [3:0] be16_n;
    wire [23:0] addr8;
    wire [23:0] addr16;

    assign lane_sel = i_addr[1:0];
    assign be8_n = ~(4'h 1 << lane_sel);
    assign be16_n = i_addr[wmblm_pkg::HALF_SEL] ?
                    wmblm_pkg::BE_HIGH_N : wmblm_pkg::BE_LOW_N;
    assign addr8 = {{wmblm_pkg::SHIFT_8{i_addr[wmblm_pkg::ADDR_MSB]}},
                    i_addr[23:wmblm_pkg::SHIFT_8]};
    assign addr16 = {{wmblm_pkg::SHIFT_16{i_addr[wmblm_pkg::ADDR_MSB]}},
                     i_addr[23:wmblm_pkg::SHIFT_16]};
    assign o_ext_addr = (i_size == 2'(wmblm_pkg::SIZE_8))  ? addr8  :
                        (i_size == 2'(wmblm_pkg::SIZE_16)) ? addr16 :
                        i_addr;
    assign o_be_n     = (i_size == 2'(wmblm_pkg::SIZE_8))  ? be8_n  :
                        (i_size == 2'(wmblm_pkg::SIZE_16)) ? be16_n :
                        wmblm_pkg::BE_ALL_N;
endmodule : wmblm_lane_decode

// ---- logic/wmblm_top.sv ----
`timescale 1ns/1ps
module wmblm_top
(
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_ARST_N,
    // Core side
    input  wire logic        I_REQ,
    input  wire logic        I_WR,
    input  wire logic [23:0] I_ADDR,
    input  wire logic [1:0]  I_SIZE,
    input  wire logic [31:0] I_WDATA,
    output logic      [31:0] O_RDATA,
    output logic             O_RVALID,
    // Memory side
    output logic      [23:0] O_EXT_ADDR,
    output logic             O_BYTE_LANE0_ENABLE_N,
    output logic             O_BYTE_LANE1_ENABLE_N,
    output logic             O_BYTE_LANE2_ENABLE_N,
    output logic             O_BYTE_LANE3_ENABLE_N,
    output logic             O_WE_N,
    output logic      [31:0] O_DQ,
    output logic             O_DQ_OE,
    input  wire logic [31:0] I_DQ
);
    logic [23:0] ext_addr_ff;
    logic [3:0]  be_n_ff;
    logic        we_n_ff;
    logic [31:0] dq_ff;
    logic        dq_oe_ff;
    logic        rd_pend_ff;
    logic [1:0]  rd_size_ff;
    logic [1:0]  rd_lane_ff;
    logic [31:0] rdata_ff;
    logic        rvalid_ff;

    wire  [23:0] map_addr;
    wire  [3:0]  map_be_n;
    wire  [3:0]  nxt_be_n;
    wire  [31:0] lane_wdata;
    wire  [31:0] nxt_rdata;
    wire  [7:0]  rd_byte;
    wire  [15:0] rd_half;
    wire  [23:0] nxt_ext_addr;
    wire         nxt_we_n;
    wire  [31:0] nxt_dq;
    wire         nxt_dq_oe;
    wire         nxt_rd_pend;
    wire  [1:0]  nxt_rd_size;
    wire  [1:0]  nxt_rd_lane;
    wire         nxt_rvalid;
    wire         wr_req;
    wire         rd_req;

    wmblm_lane_decode u_decode
    (
        .i_addr     (I_ADDR),
        .i_size     (I_SIZE),
        .o_ext_addr (map_addr),
        .o_be_n     (map_be_n)
    );

    // Steers a right-justified value to its lanes
    function automatic logic [31:0] place(input logic [31:0] v,
                                          input logic [1:0]  sz,
                                          input logic [1:0]  ln);
        logic [31:0] r;
        r = v;
        if (sz == 2'(wmblm_pkg::SIZE_8))
            r = {24'h00_0000, v[7:0]} << {ln, 3'h 0};
        else if (sz == 2'(wmblm_pkg::SIZE_16))
            r = ln[0] ? {v[15:0], 16'h0000} : {16'h0000, v[15:0]};
        return r;
    endfunction : place

    // Size code compare; the spare code falls through to word
    function automatic logic size_is(input logic [1:0]             sz,
                                     input wmblm_pkg::wmblm_size_e k);
        return sz == 2'(k);
    endfunction : size_is

    assign wr_req       = I_REQ & I_WR;
    assign rd_req       = I_REQ & ~I_WR;

    assign nxt_be_n     = I_REQ ? map_be_n : wmblm_pkg::BE_IDLE_N;
    assign nxt_ext_addr = I_REQ ? map_addr : ext_addr_ff;
    assign nxt_we_n     = ~wr_req;
    assign nxt_dq_oe    = wr_req;
    assign lane_wdata   = place(I_WDATA, I_SIZE, I_ADDR[1:0]);
    assign nxt_dq       = wr_req ? lane_wdata : dq_ff;
    assign nxt_rd_pend  = rd_req;
    assign nxt_rd_size  = I_REQ ? I_SIZE : rd_size_ff;
    assign nxt_rd_lane  = I_REQ ? I_ADDR[1:0] : rd_lane_ff;
    assign nxt_rvalid   = rd_pend_ff;
    assign rd_byte      = 8'(I_DQ >> {rd_lane_ff, 3'h 0});
    assign rd_half      = rd_lane_ff[0] ? I_DQ[31:16] : I_DQ[15:0];
    // Data sampled at the edge that ends the strobe cycle: no wait states, so a
    // slower memory needs its own wrapper in front of this block
    assign nxt_rdata    = !rd_pend_ff ? rdata_ff
                        : size_is(rd_size_ff, wmblm_pkg::SIZE_8)
                        ? {24'h00_0000, rd_byte}
                        : size_is(rd_size_ff, wmblm_pkg::SIZE_16)
                        ? {16'h0000, rd_half} : I_DQ;

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            ext_addr_ff <= wmblm_pkg::ADDR_RST;
        end
        else
        begin
            ext_addr_ff <= nxt_ext_addr;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            be_n_ff <= wmblm_pkg::BE_IDLE_N;
        end
        else
        begin
            be_n_ff <= nxt_be_n;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            we_n_ff <= 1'b1;
        end
        else
        begin
            we_n_ff <= nxt_we_n;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            dq_ff <= wmblm_pkg::DATA_RST;
        end
        else
        begin
            dq_ff <= nxt_dq;
        end
    end

    // Lanes driven only in the strobe cycle of a write
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            dq_oe_ff <= 1'b0;
        end
        else
        begin
            dq_oe_ff <= nxt_dq_oe;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rd_pend_ff <= 1'b0;
        end
        else
        begin
            rd_pend_ff <= nxt_rd_pend;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rd_size_ff <= 2'h0;
        end
        else
        begin
            rd_size_ff <= nxt_rd_size;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rd_lane_ff <= 2'h0;
        end
        else
        begin
            rd_lane_ff <= nxt_rd_lane;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rdata_ff <= wmblm_pkg::DATA_RST;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign O_EXT_ADDR            = ext_addr_ff;
    assign O_BYTE_LANE0_ENABLE_N = be_n_ff[0];
    assign O_BYTE_LANE1_ENABLE_N = be_n_ff[1];
    assign O_BYTE_LANE2_ENABLE_N = be_n_ff[2];
    assign O_BYTE_LANE3_ENABLE_N = be_n_ff[3];
    assign O_WE_N                = we_n_ff;
    assign O_DQ                  = dq_ff;
    assign O_DQ_OE               = dq_oe_ff;
    assign O_RDATA               = rdata_ff;
    assign O_RVALID              = rvalid_ff;
endmodule : wmblm_top

// ---- dv/wmblm_props.sv ----
`timescale 1ns/1ps
module wmblm_props
(
    // Watched ports
    input wire logic        I_SYS_CLK, I_ARST_N, I_REQ, I_WR, O_RVALID,
    input wire logic [1:0]  I_SIZE,
    input wire logic        O_WE_N, O_DQ_OE,
    input wire logic [23:0] I_ADDR, O_EXT_ADDR,
    input wire logic [31:0] I_WDATA, O_DQ,
    input wire logic        O_BYTE_LANE0_ENABLE_N, O_BYTE_LANE1_ENABLE_N,
    input wire logic        O_BYTE_LANE2_ENABLE_N, O_BYTE_LANE3_ENABLE_N
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);
    logic      [23:0] a_ff;
    logic      [31:0] d_ff;
    wire logic [3:0]  be_n = {O_BYTE_LANE3_ENABLE_N, O_BYTE_LANE2_ENABLE_N,
        O_BYTE_LANE1_ENABLE_N, O_BYTE_LANE0_ENABLE_N};
    wire logic        b = I_REQ && I_SIZE == 2'h0;
    wire logic        h = I_REQ && I_SIZE == 2'h1;
    wire logic        w = I_REQ && I_SIZE[1];
    wire logic        wq = I_REQ && I_WR;
    always_ff @(posedge I_SYS_CLK)
    begin
        a_ff <= I_ADDR;
        d_ff <= I_WDATA;
    end
    property p_a8; b |=> O_EXT_ADDR == {{2{a_ff[23]}}, a_ff[23:2]}; endproperty
    a_a8: assert property (p_a8) else $error("byte addr");
    property p_a16; h |=> O_EXT_ADDR == {a_ff[23], a_ff[23:1]}; endproperty
    a_a16: assert property (p_a16) else $error("half addr");
    property p_a32; w |=> O_EXT_ADDR == a_ff; endproperty
    a_a32: assert property (p_a32) else $error("word addr");
    property p_b8; b |=> be_n == ~(4'h1 << a_ff[1:0]); endproperty
    a_b8: assert property (p_b8) else $error("byte lane");
    property p_b16; h |=> be_n == (a_ff[0] ? 4'h3 : 4'hc); endproperty
    a_b16: assert property (p_b16) else $error("half lanes");
    property p_b32; w |=> be_n == 4'h0; endproperty
    a_b32: assert property (p_b32) else $error("word lanes");
    property p_idle; !I_REQ |=> be_n == 4'hf; endproperty
    a_idle: assert property (p_idle) else $error("idle lanes");
    property p_rd; I_REQ && !I_WR |-> ##2 O_RVALID; endproperty
    a_rd: assert property (p_rd) else $error("read answer");
    property p_wr; wq |=> !O_WE_N && O_DQ_OE; endproperty
    a_wr: assert property (p_wr) else $error("write strobe");
    property p_nwr; !wq |=> O_WE_N && !O_DQ_OE; endproperty
    a_nwr: assert property (p_nwr) else $error("no write");
    property p_d8;
        b && I_WR |=> O_DQ[a_ff[1:0]*8 +: 8] == d_ff[7:0];
    endproperty
    a_d8: assert property (p_d8) else $error("byte data");
    property p_d16;
        h && I_WR |=> O_DQ[a_ff[0]*16 +: 16] == d_ff[15:0];
    endproperty
    a_d16: assert property (p_d16) else $error("half data");
    property p_d32; w && I_WR |=> O_DQ == d_ff; endproperty
    a_d32: assert property (p_d32) else $error("word data");
endmodule : wmblm_props
bind wmblm_top wmblm_props u_props (.*);

// ---- dv/wmblm_sram_model.sv ----
`timescale 1ns/1ps
module wmblm_sram_model
(
    // Memory pins
    input  wire logic        i_clk, i_we_n,
    input  wire logic [23:0] i_addr,
    input  wire logic [3:0]  i_be_n,
    input  wire logic [31:0] i_dq,
    output logic      [31:0] o_dq
);
    logic [31:0] mem_ff [64] = '{default: 32'h0000_0000};
    logic [31:0] last_ff = 32'h0000_0000;
    wire logic   rd = i_be_n != 4'hf && i_we_n;
    // Released bus shows the inverse, so a stale value never matches
    assign o_dq = rd ? mem_ff[i_addr[5:0]] : ~last_ff;
    always @(posedge i_clk)
    begin
        if (rd)
            last_ff <= o_dq;
        for (int l = 0; l < 4; l++)
            if (!i_we_n && !i_be_n[l])
                mem_ff[i_addr[5:0]][l*8 +: 8] <= i_dq[l*8 +: 8];
    end
endmodule : wmblm_sram_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic        clk = 0, rst_n = 0, req = 0, wr = 0, rv, we_n, r, w;
    logic [1:0]  size = 2'h0, s;
    logic [23:0] addr = 24'h00_0000, ext, a, x;
    wire  [3:0]  be_n;
    logic [31:0] wd = 32'h0000_0000, rd, dq, dqi, d, m;
    logic [31:0] mem [64] = '{default: 32'h0000_0000};
    logic [31:0] exp_q [$];
    int          bad_count = 0, checks = 0, sh;
    initial forever #4 clk = ~clk;
    wmblm_top dut (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_REQ(req),
        .I_WR(wr), .I_ADDR(addr), .I_SIZE(size), .I_WDATA(wd), .O_RDATA(rd),
        .O_RVALID(rv), .O_EXT_ADDR(ext), .O_BYTE_LANE0_ENABLE_N(be_n[0]),
        .O_BYTE_LANE1_ENABLE_N(be_n[1]), .O_BYTE_LANE2_ENABLE_N(be_n[2]),
        .O_BYTE_LANE3_ENABLE_N(be_n[3]), .O_WE_N(we_n), .O_DQ(dq),
        .O_DQ_OE(), .I_DQ(dqi));
    wmblm_sram_model u_mem (.i_clk(clk), .i_addr(ext), .i_be_n(be_n),
        .i_we_n(we_n), .i_dq(dq), .o_dq(dqi));
    task automatic report_and_stop;
        // Reads still owed an answer count as lost
        if (exp_q.size() != 0)
            bad_count++;
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic run(input int n);
        repeat (n)
        begin
            @(posedge clk);
            r = $urandom_range(3) != 0;
            {w, s, a} = 27'($urandom);
            d = $urandom;
            x = s[1] ? a : s[0] ? {a[23], a[23:1]} : {{2{a[23]}}, a[23:2]};
            sh = s[1] ? 0 : s[0] ? 16 * a[0] : 8 * a[1:0];
            m = s[1] ? '1 : s[0] ? 32'h0000_ffff : 32'h0000_00ff;
            if (r && w)
                mem[x[5:0]] = mem[x[5:0]] & ~(m << sh) | (d & m) << sh;
            if (r && !w)
                exp_q.push_back(mem[x[5:0]] >> sh & m);
            req <= r;
            wr <= w;
            addr <= a;
            size <= s;
            wd <= d;
        end
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : run
    always @(posedge clk)
        if (rv === 1'b1 && exp_q.size() == 0)
        begin
            // An answer with no read behind it
            bad_count++;
            $display("MISMATCH %0t exp=%h got=%h", $time, 32'h0, rd);
        end
        else if (rv === 1'b1)
            chk(rd, exp_q.pop_front());
    initial
    begin
        // The run needs about 2030 cycles
        #80000 bad_count++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'h8257_c18a));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        run(1000);
        // Second reset; the memory keeps its contents across it
        rst_n <= 1'b0;
        @(posedge clk);
        chk({28'h000_0000, be_n}, 32'h0000_000f);
        chk({30'h0000_0000, we_n, rv}, 32'h0000_0002);
        chk({8'h00, ext}, 32'h0000_0000);
        chk(dq, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        rst_n <= 1'b1;
        run(1000);
        report_and_stop();
    end
endmodule : tb
